// [rtl/host_window_region0_bounds.sv]
/*
 region 0 relocation and bounds check for host window accesses, with its registers.
 assumes the window port logic issues one-cycle access pulses on this clock and
 internal memory returns read data one cycle after a read request.
*/
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "region0_cfg.svh"

//Function
//RULE_01 - a writable region 0 base is held in bits 31:2 with bits 1:0 reserved.
//RULE_02 - base and limits apply only when offset bit 15 is zero.
//RULE_03 - a region 0 access goes to base plus window offset.
//RULE_04 - a region 0 read compares offset bits 14:2 with the 13-bit read limit.
//RULE_05 - the data port is loaded from memory only when offset bits 14:2 are below the read limit.
//RULE_06 - a region 0 write compares offset bits 14:2 with the write limit.
//RULE_07 - an in-range write copies only the addressed bytes to memory.
//RULE_08 - a write at or above the write limit never reaches memory, though its addressed lanes still load the data port when no read return is pending.
//RULE_09 - an out-of-range read leaves the data port unchanged.
//RULE_10 - all three region 0 registers reset to zero.
module host_window_region0_bounds (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [15:0] window_offset,
   input wire logic [31:0] window_wdata,
   input wire logic [3:0] window_be,
   input wire logic window_rd,
   input wire logic window_wr,
   output region0_pkg::mem_req_t mem_req,
   input wire logic [31:0] mem_rdata,
   output logic [31:0] window_data_port
);
   logic [31:0] base_q;
   logic [15:0] rdlim_q;
   logic [15:0] wrlim_q;
   logic rd_pend_q;
   logic sel0;
   logic rd_ok;
   logic wr_ok;
   logic [31:0] tgt_addr;
   logic [12:0] ofs_word;
   wire [31:0] port_lanes;

   assign sel0 = ~window_offset[`R0_SEL_BIT]; // RULE_02
   assign ofs_word = window_offset[`R0_LIM_HI:`R0_LIM_LO];
   assign rd_ok = sel0 && (ofs_word < rdlim_q[`R0_LIM_HI:`R0_LIM_LO]); // RULE_04
   assign wr_ok = sel0 && (ofs_word < wrlim_q[`R0_LIM_HI:`R0_LIM_LO]); // RULE_06
   assign tgt_addr = base_q + {16'h0000, window_offset}; // RULE_03

   // register writes
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         base_q <= `R0_BASE_RST; // RULE_10
         rdlim_q <= `R0_LIM_RST; // RULE_10
         wrlim_q <= `R0_LIM_RST; // RULE_10
      end else if (reg_wr) begin
         case (reg_addr)
            `R0_BASE_OFS: base_q <= {reg_wdata[31:2], 2'h0}; // RULE_01
            `R0_RDLIM_OFS: rdlim_q <= {1'b0, reg_wdata[14:2], 2'h0};
            `R0_WRLIM_OFS: wrlim_q <= {1'b0, reg_wdata[14:2], 2'h0};
            default: ;
         endcase
      end
   end

   // register reads, one cycle later
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `R0_BASE_OFS: reg_rdata <= base_q;
            `R0_RDLIM_OFS: reg_rdata <= {16'h0000, rdlim_q};
            `R0_WRLIM_OFS: reg_rdata <= {16'h0000, wrlim_q};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // memory request issue
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mem_req <= '0;
      end else begin
         mem_req.addr <= tgt_addr; // RULE_03
         mem_req.wdata <= window_wdata;
         mem_req.be <= window_be; // RULE_07
         mem_req.wr <= window_wr && wr_ok; // RULE_08
         mem_req.rd <= window_rd && rd_ok; // RULE_05
      end
   end

   // fetch pending only for in-range reads
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= mem_req.rd; // RULE_09
      end
   end

   // read return or write lanes into the data port
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         window_data_port <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         window_data_port <= mem_rdata; // RULE_05
      end else if (window_wr && sel0) begin
         window_data_port <= port_lanes; // RULE_07
      end
   end

   // per lane write merge and its checks
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : g_lane
         assign port_lanes[lane*8 +: 8] = window_be[lane] ?
            window_wdata[lane*8 +: 8] : window_data_port[lane*8 +: 8]; // RULE_07

         a_lane_taken: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
            (window_wr && sel0 && !rd_pend_q && window_be[lane])
            |=> window_data_port[lane*8 +: 8] == $past(window_wdata[lane*8 +: 8]))
            else $error("addressed data port lane not written");
         a_lane_kept: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
            (window_wr && sel0 && !rd_pend_q && !window_be[lane])
            |=> $stable(window_data_port[lane*8 +: 8]))
            else $error("unaddressed data port lane changed");
      end
   endgenerate

   a_write_blocked: assert property (@(posedge clock) disable iff (!nrst) // RULE_08
      (window_wr && sel0 && ofs_word >= wrlim_q[14:2]) |=> !mem_req.wr)
      else $error("out of range write reached memory");
   a_write_passes: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
      (window_wr && wr_ok) |=> (mem_req.wr && mem_req.be == $past(window_be)))
      else $error("in range write lost or wrong lanes");
   sequence s_read_refused;
      (window_rd && !rd_ok && !window_wr && !rd_pend_q) ##1 (!mem_req.wr && !window_wr);
   endsequence

   sequence s_read_taken;
      window_rd && rd_ok;
   endsequence

   sequence s_read_return;
      mem_req.rd ##2 (window_data_port == $past(mem_rdata));
   endsequence

   a_read_blocked: assert property (@(posedge clock) disable iff (!nrst) // RULE_09
      s_read_refused |=> $stable(window_data_port))
      else $error("out of range read changed data port");
   a_read_issue: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
      s_read_taken |=> s_read_return)
      else $error("in range read not loaded");
   a_addr_reloc: assert property (@(posedge clock) disable iff (!nrst) // RULE_03
      (window_rd || window_wr) |=> mem_req.addr == $past(base_q) + {16'h0, $past(window_offset)})
      else $error("target address wrong");
   a_region1_quiet: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
      window_offset[15] |=> (!mem_req.rd && !mem_req.wr))
      else $error("region 1 access passed region 0 check");
   a_base_low_zero: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
      reg_rd && reg_addr == `R0_BASE_OFS |=> reg_rdata[1:0] == 2'h0)
      else $error("base reserved bits nonzero");
   a_rdlim_check: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
      (window_rd && sel0 && ofs_word >= rdlim_q[14:2]) |=> !mem_req.rd)
      else $error("out of range read fetched memory");
   a_wrlim_check: assert property (@(posedge clock) disable iff (!nrst) // RULE_06
      (window_wr && sel0 && ofs_word < wrlim_q[14:2]) |=> mem_req.wr)
      else $error("write limit compare wrong");

   // register side checks
   a_base_load: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
      (reg_wr && reg_addr == `R0_BASE_OFS)
      |=> base_q[31:2] == $past(reg_wdata[31:2]))
      else $error("base write not taken");
   a_rdlim_load: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
      (reg_wr && reg_addr == `R0_RDLIM_OFS)
      |=> rdlim_q[`R0_LIM_HI:`R0_LIM_LO] == $past(reg_wdata[`R0_LIM_HI:`R0_LIM_LO]))
      else $error("read limit write not taken");
   a_wrlim_load: assert property (@(posedge clock) disable iff (!nrst) // RULE_06
      (reg_wr && reg_addr == `R0_WRLIM_OFS)
      |=> wrlim_q[`R0_LIM_HI:`R0_LIM_LO] == $past(reg_wdata[`R0_LIM_HI:`R0_LIM_LO]))
      else $error("write limit write not taken");
   a_lim_reserved: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
      (reg_rd && (reg_addr == `R0_RDLIM_OFS || reg_addr == `R0_WRLIM_OFS))
      |=> (reg_rdata[15] == 1'b0 && reg_rdata[1:0] == 2'h0))
      else $error("limit reserved bits nonzero");
   a_unmapped_zero: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
      (reg_rd && reg_addr != `R0_BASE_OFS && reg_addr != `R0_RDLIM_OFS
      && reg_addr != `R0_WRLIM_OFS)
      |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (@(posedge clock) disable iff (!nrst) // RULE_01
      !reg_rd
      |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   a_reset_closed: assert property (@(posedge clock) // RULE_10
      $rose(nrst)
      |-> (base_q == `R0_BASE_RST && rdlim_q == `R0_LIM_RST && wrlim_q == `R0_LIM_RST))
      else $error("region registers not cleared by reset");

   // window side checks
   a_wdata_pass: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
      (window_wr && wr_ok)
      |=> mem_req.wdata == $past(window_wdata))
      else $error("write data not passed to memory");
   a_read_no_wr: assert property (@(posedge clock) disable iff (!nrst) // RULE_08
      (window_rd && !window_wr)
      |=> !mem_req.wr)
      else $error("read raised a memory write");
   a_write_no_rd: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
      (window_wr && !window_rd)
      |=> !mem_req.rd)
      else $error("write raised a memory read");

   sequence s_region1_read;
      (window_rd && !sel0 && !window_wr && !rd_pend_q && !mem_req.rd) ##1 !window_wr;
   endsequence

   a_region1_port: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
      s_region1_read
      |=> $stable(window_data_port))
      else $error("region 1 read changed data port");
endmodule // host_window_region0_bounds

// [inc/region0_cfg.svh]
/*
 region 0 window bounds block: register offsets, field positions, reset values.
 assumes a plain register port with byte offsets as printed.
*/
`ifndef REGION0_CFG_SVH
`define REGION0_CFG_SVH
`define R0_BASE_OFS 12'h104
`define R0_RDLIM_OFS 12'h108
`define R0_WRLIM_OFS 12'h10A
`define R0_SEL_BIT 15
`define R0_LIM_HI 14
`define R0_LIM_LO 2
`define R0_BASE_RST 32'h0000_0000
`define R0_LIM_RST 16'h0000
`endif

// [inc/region0_pkg.sv]
/*
 types for the region 0 window bounds block.
 assumes nothing beyond the cfg header.
*/
package region0_pkg;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic wr;
      logic rd;
   } mem_req_t;
endpackage

// [test/mem_model.sv]
/* internal memory model for the region 0 block.
 assumes read data is wanted one cycle after a read pulse. */
`timescale 1ns/1ns
module mem_model (
   input wire logic clock,
   input wire region0_pkg::mem_req_t mem_req,
   output logic [31:0] mem_rdata
);
   initial mem_rdata = 32'h0;
   // data tied to address; flips every idle cycle
   always @(posedge clock) begin
      mem_rdata <= mem_req.rd ? mem_req.addr ^ 32'h5A5A_0000 : ~mem_rdata;
   end
endmodule // mem_model

// [test/tb.sv]
/* self-checking bench for the region 0 bounds block.
 assumes the memory model answers one cycle after a read pulse. */
`timescale 1ns/1ns
module tb;
   logic clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, window_rd = 0, window_wr = 0;
   logic [11:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, window_wdata = 0, base, d, p, reg_rdata, mem_rdata, window_data_port;
   logic [15:0] window_offset = 0;
   logic [15:0] ofs[4] = '{16'h001C, 16'h003C, 16'h0040, 16'h8004};
   logic [3:0] window_be = 0;
   logic rp = 0;
   logic [12:0] rl = 0, wl = 0;
   region0_pkg::mem_req_t mem_req;
   logic [69:0] mq[$];
   logic [31:0] rq[$];
   int bad_count = 0, num_checks = 0;
   always #25 clock = ~clock;
   host_window_region0_bounds i_dut (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .window_offset, .window_wdata, .window_be, .window_rd, .window_wr, .mem_req,
      .mem_rdata, .window_data_port);
   mem_model i_mem (.clock, .mem_req, .mem_rdata);
   task chk_mem(input logic [69:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t mem got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_reg(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_port(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t port got %h exp %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task rw(input logic [11:0] a, input logic [31:0] v, input logic w, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= w;
      reg_rd <= !w;
      if (!w) rq.push_back(e);
      @(posedge clock);
      reg_wr <= 0;
      reg_rd <= 0;
   endtask
   task win(input logic [15:0] o, input logic w);
      logic ok;
      logic [3:0] be;
      ok = !o[15] && o[14:2] < (w ? wl : rl);
      d = $urandom;
      be = $urandom;
      p = window_data_port;
      @(posedge clock);
      window_offset <= o;
      window_wdata <= d;
      window_be <= be;
      window_rd <= !w;
      window_wr <= w;
      if (ok) mq.push_back({base + o, w ? {d, be} : 36'h0, w, !w});
      @(posedge clock);
      window_rd <= 0;
      window_wr <= 0;
      repeat (4) @(posedge clock);
      if (!w) chk_port(window_data_port, ok ? (base + o) ^ 32'h5A5A_0000 : p);
   endtask
   // results are taken off the queue in arrival order
   always @(posedge clock) begin
      rp <= reg_rd;
      if (rp) chk_reg(reg_rdata, rq.size() ? rq.pop_front() : 'x);
      if (nrst && (mem_req.wr | mem_req.rd) !== 1'b0)
         chk_mem({mem_req.addr, mem_req.rd ? 36'h0 : {mem_req.wdata, mem_req.be}, mem_req.wr,
            mem_req.rd}, mq.size() ? mq.pop_front() : '1);
   end
   initial begin
      void'($urandom(32'hBB15));
      repeat (4) @(posedge clock);
      nrst <= 1;
      base = 0;
      for (int i = 0; i < 3; i++) rw(12'h104 + 12'(i * 4 - i / 2 * 2), 0, 0, 0);
      win(16'h0, 0);
      win(16'h0, 1);
      base = $urandom;
      rw(12'h104, base, 1, 0);
      base[1:0] = 2'h0;
      rw(12'h104, 0, 0, base);
      rw(12'h108, 32'hFFFF_FFFF, 1, 0);
      rw(12'h108, 0, 0, 32'h7FFC);
      rw(12'h108, 32'h40, 1, 0);
      rw(12'h10A, 32'h20, 1, 0);
      rw(12'h10A, 0, 0, 32'h20);
      rl = 13'h10;
      wl = 13'h8;
      rw(12'h10C, 32'h1, 1, 0);
      rw(12'h10C, 0, 0, 0);
      $display("registers done");
      for (int i = 0; i < 12; i++) win(i < 8 ? ofs[i / 2] : 16'($urandom) & 16'h80FC, i[0]);
      $display("window done");
      summarize;
   end
   initial begin
      #50000;
      bad_count++;
      summarize;
   end
endmodule // tb
